// >>> uart_sleep_params.svh
// Constants for the UART sleep controller, idle detector and baud generator
`ifndef UART_SLEEP_PARAMS_SVH
`define UART_SLEEP_PARAMS_SVH

// ----------------------------------------------------------------------------
// Baud generator
// ----------------------------------------------------------------------------
`define DIVISOR_ZERO      16'h0000
`define DIVISOR_ONE       16'h0001
`define PRESCALE_LAST     2'h3
`define PRESCALE_RESET    1'b0
`define OVERSAMPLE_LAST   4'hF

// ----------------------------------------------------------------------------
// Receive idle detection
// ----------------------------------------------------------------------------
`define BIT_MID_PHASE     4'h7
`define WORD_LEN_BASE     6'h05
`define IDLE_WORD_MULT    6'h04
`define IDLE_EXTRA_BITS   6'h0C

// ----------------------------------------------------------------------------
// Reset levels
// ----------------------------------------------------------------------------
`define TX_RESET_LEVEL    1'b1
`define RX_RESET_LEVEL    1'b1
`define MODEM_RESET_LEVEL 4'hF

`endif

// >>> uart_sleep_pkg.sv
// Types shared by the UART sleep and baud generator design
package uart_sleep_pkg;

  // --------------------------------------------------------------------------
  // Sleep controller states
  // --------------------------------------------------------------------------
  typedef enum logic [0:0] {
    st_awake  = 1'b0,
    st_asleep = 1'b1
  } sleep_state_t;

  // --------------------------------------------------------------------------
  // Modem input pins and pending interrupt sources
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic cts;
    logic dsr;
    logic ri;
    logic cd;
  } modem_pins_t;

  typedef struct packed {
    logic line_status;
    logic rx_data;
    logic rx_timeout;
    logic thr_empty;
    logic modem;
    logic xoff;
    logic flow;
  } irq_pending_t;

endpackage

// >>> baud_gen.sv
// Prescaler and 16-bit divisor producing the 16x bit-rate enable
`timescale 1ns/1ps
`include "uart_sleep_params.svh"

module baud_gen #(
  parameter int DIV_W = 16
) (
  input  wire logic             clock_in,
  input  wire logic             rst_n_in,
  input  wire logic             run_in,
  input  wire logic             prescale4_in,
  input  wire logic [DIV_W-1:0] divisor_in,
  output logic                  tick_out
);

  logic [1:0]       pre_q, pre_d;
  logic [DIV_W-1:0] cnt_q, cnt_d;
  logic             tick_q, tick_d;
  logic             pre_en;

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  // Prescaler then divisor, both frozen while asleep
  always_comb begin
    pre_en = run_in && (!prescale4_in || pre_q == `PRESCALE_LAST);
    pre_d  = pre_q;
    cnt_d  = cnt_q;
    tick_d = 1'b0;
    if (run_in) begin
      pre_d = prescale4_in ? 2'(pre_q + 2'h1) : 2'h0;
    end
    if (pre_en && divisor_in != `DIVISOR_ZERO) begin
      if (cnt_q >= DIV_W'(divisor_in - `DIVISOR_ONE)) begin
        cnt_d  = '0;
        tick_d = 1'b1;
      end else begin
        cnt_d = DIV_W'(cnt_q + 1'b1);
      end
    end
  end

  // Registers
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pre_q  <= 2'h0;
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_out = tick_q;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  AST_BAUD_ZERO: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    divisor_in == `DIVISOR_ZERO |=> !tick_q)
    else $error("baud tick with zero divisor");

  AST_BAUD_DIV1: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    run_in && !prescale4_in && divisor_in == `DIVISOR_ONE |=> tick_q)
    else $error("divisor one did not tick every cycle");

  AST_BAUD_PRE4: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    tick_q && prescale4_in |=> !tick_q ##1 !tick_q)
    else $error("prescaler four ticked too soon");

endmodule // baud_gen

// >>> rx_idle_detect.sv
// Mid-bit sampling of the receive line and idle bit-time counter
`timescale 1ns/1ps
`include "uart_sleep_params.svh"

module rx_idle_detect (
  input  wire logic       clock_in,
  input  wire logic       rst_n_in,
  input  wire logic       tick_in,
  input  wire logic       rx_in,
  input  wire logic [1:0] word_len_in,
  output logic            idle_out
);

  logic [3:0] phase_q, phase_d;
  logic [5:0] count_q, count_d;
  logic       prev_q, prev_d;
  logic       idle_q, idle_d;
  logic       sample_stb;
  logic [5:0] limit;

  // ----------------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------------
  // Falling edge realigns the bit phase and restarts the idle count; sample taken mid-bit
  always_comb begin
    limit      = 6'(`IDLE_WORD_MULT * (`WORD_LEN_BASE + 6'(word_len_in)) + `IDLE_EXTRA_BITS);
    sample_stb = tick_in && phase_q == `BIT_MID_PHASE;
    prev_d     = rx_in;
    phase_d    = phase_q;
    count_d    = count_q;
    if (prev_q && !rx_in) begin
      phase_d = 4'h0;
    end else if (tick_in) begin
      phase_d = 4'(phase_q + 4'h1);
    end
    if (!rx_in && (prev_q || sample_stb)) begin
      count_d = 6'h00;
    end else if (sample_stb && count_q < limit) begin
      count_d = 6'(count_q + 6'h01);
    end
    idle_d = count_d >= limit;
  end

  // Registers
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      phase_q <= 4'h0;
      count_q <= 6'h00;
      prev_q  <= `RX_RESET_LEVEL;
      idle_q  <= 1'b0;
    end else begin
      phase_q <= phase_d;
      count_q <= count_d;
      prev_q  <= prev_d;
      idle_q  <= idle_d;
    end
  end

  assign idle_out = idle_q;

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  AST_IDLE_RESTART: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    sample_stb && !rx_in |=> count_q == 6'h00 && !idle_q)
    else $error("idle counter did not restart on low sample");

  AST_IDLE_HOLD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    count_q == limit && !(!rx_in && (prev_q || sample_stb)) && $stable(word_len_in)
    |=> count_q == $past(count_q) && idle_q)
    else $error("idle counter left its limit");

  AST_IDLE_EDGE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    prev_q && !rx_in |=> count_q == 6'h00 && !idle_q)
    else $error("idle flag kept after a falling edge");

endmodule // rx_idle_detect

// >>> uart_sleep_ctrl.sv
// UART channel sleep controller, break drive and baud generator top
`timescale 1ns/1ps
`include "uart_sleep_params.svh"

module uart_sleep_ctrl (
  input  wire logic                       clock_in,
  input  wire logic                       rst_n_in,
  // Serial and modem pins
  input  wire logic                       rx_pin_in,
  input  wire uart_sleep_pkg::modem_pins_t modem_pins_in,
  input  wire logic                       tx_data_in,
  output logic                            tx_out,
  // Configuration bits
  input  wire logic                       enh_functions_in,
  input  wire logic                       sleep_enable_in,
  input  wire logic                       break_ctrl_in,
  input  wire logic [1:0]                 word_len_in,
  input  wire logic                       prescale_sel_in,
  // Divisor byte writes
  input  wire logic                       div_low_wr_in,
  input  wire logic                       div_high_wr_in,
  input  wire logic [7:0]                 div_data_in,
  // Channel status from the datapath
  input  wire logic                       thr_write_in,
  input  wire logic                       tx_fifo_empty_in,
  input  wire logic                       tx_shift_empty_in,
  input  wire logic                       rx_fifo_empty_in,
  input  wire uart_sleep_pkg::irq_pending_t irq_pending_in,
  // Status and clock enables
  output logic                            sleeping_out,
  output logic                            uart_clk_en_out,
  output logic                            baud_tick_out,
  output logic                            rx_idle_out,
  output logic [15:0]                     divisor_out
);

  // ----------------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------------
  uart_sleep_pkg::sleep_state_t state_q, state_d;
  uart_sleep_pkg::modem_pins_t  modem_s1_q, modem_s2_q, modem_s3_q;
  logic                         rx_s1_q, rx_s2_q, rx_s3_q;
  logic [7:0]                   div_low_q, div_low_d;
  logic [7:0]                   div_high_q, div_high_d;
  logic                         prescale_q, prescale_d;
  logic                         tx_q, tx_d;
  logic                         sleeping_q, sleeping_d;
  logic                         clk_en_q, clk_en_d;
  logic                         rx_change;
  logic                         modem_change;
  logic                         wake_event;
  logic                         sleep_allowed;
  logic                         blocking_irq;
  logic                         can_sleep;
  logic                         baud_tick;
  logic                         rx_idle;

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  // Two stages before use, third stage for change detection
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rx_s1_q    <= `RX_RESET_LEVEL;
      rx_s2_q    <= `RX_RESET_LEVEL;
      rx_s3_q    <= `RX_RESET_LEVEL;
      modem_s1_q <= `MODEM_RESET_LEVEL;
      modem_s2_q <= `MODEM_RESET_LEVEL;
      modem_s3_q <= `MODEM_RESET_LEVEL;
    end else begin
      rx_s1_q    <= rx_pin_in;
      rx_s2_q    <= rx_s1_q;
      rx_s3_q    <= rx_s2_q;
      modem_s1_q <= modem_pins_in;
      modem_s2_q <= modem_s1_q;
      modem_s3_q <= modem_s2_q;
    end
  end

  // ----------------------------------------------------------------------------
  // Wake and sleep conditions
  // ----------------------------------------------------------------------------
  // Change detectors on the free clock, never gated by sleep
  assign rx_change    = rx_s2_q != rx_s3_q;
  assign modem_change = modem_s2_q != modem_s3_q;
  assign wake_event   = rx_change || modem_change || thr_write_in;

  // Enable bits, idle line, empty transmitter and receive FIFO, no line status, receive data, modem, xoff or flow interrupt
  assign sleep_allowed = enh_functions_in && sleep_enable_in;
  assign blocking_irq  = irq_pending_in.line_status || irq_pending_in.rx_data
                      || irq_pending_in.modem || irq_pending_in.xoff
                      || irq_pending_in.flow;
  assign can_sleep     = sleep_allowed && rx_idle
                      && tx_fifo_empty_in && tx_shift_empty_in
                      && !blocking_irq
                      && rx_fifo_empty_in;

  // ----------------------------------------------------------------------------
  // Sleep state machine
  // ----------------------------------------------------------------------------
  // Enter when every condition holds; any wake event or lost condition leaves
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      uart_sleep_pkg::st_awake: begin
        if (can_sleep && !wake_event) begin
          state_d = uart_sleep_pkg::st_asleep;
        end
      end
      uart_sleep_pkg::st_asleep: begin
        if (wake_event || !can_sleep) begin
          state_d = uart_sleep_pkg::st_awake;
        end
      end
    endcase
    sleeping_d = state_d == uart_sleep_pkg::st_asleep;
    clk_en_d   = state_d == uart_sleep_pkg::st_awake;
  end

  // Registers
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q    <= uart_sleep_pkg::st_awake;
      sleeping_q <= 1'b0;
      clk_en_q   <= 1'b1;
    end else begin
      state_q    <= state_d;
      sleeping_q <= sleeping_d;
      clk_en_q   <= clk_en_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Divisor latches and prescaler select
  // ----------------------------------------------------------------------------
  // Byte writes; writes during sleep are not guarded here
  always_comb begin
    div_low_d  = div_low_q;
    div_high_d = div_high_q;
    if (div_low_wr_in) begin
      div_low_d = div_data_in;
    end
    if (div_high_wr_in) begin
      div_high_d = div_data_in;
    end
  end

  // No reset: contents survive the top-level reset
  always_ff @(posedge clock_in) begin
    div_low_q  <= div_low_d;
    div_high_q <= div_high_d;
  end

  // Prescaler select follows the modem control bit
  always_comb begin
    prescale_d = prescale_sel_in;
  end

  // Register
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      prescale_q <= `PRESCALE_RESET;
    end else begin
      prescale_q <= prescale_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Baud generator and receive idle detection
  // ----------------------------------------------------------------------------
  // Single 16x enable shared by transmitter and receiver
  baud_gen #(
    .DIV_W        (16)
  ) u_baud_gen (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .run_in       (clk_en_q),
    .prescale4_in (prescale_q),
    .divisor_in   ({div_high_q, div_low_q}),
    .tick_out     (baud_tick)
  );

  // Idle counter advances on the same 16x enable
  rx_idle_detect u_rx_idle (
    .clock_in     (clock_in),
    .rst_n_in     (rst_n_in),
    .tick_in      (baud_tick),
    .rx_in        (rx_s2_q),
    .word_len_in  (word_len_in),
    .idle_out     (rx_idle)
  );

  // ----------------------------------------------------------------------------
  // Transmit line
  // ----------------------------------------------------------------------------
  // Break holds the line low for as long as the bit is set
  always_comb begin
    tx_d = break_ctrl_in ? 1'b0 : tx_data_in;
  end

  // Register
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      tx_q <= `TX_RESET_LEVEL;
    end else begin
      tx_q <= tx_d;
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------------
  assign tx_out          = tx_q;
  assign sleeping_out    = sleeping_q;
  assign uart_clk_en_out = clk_en_q;
  assign baud_tick_out   = baud_tick;
  assign rx_idle_out     = rx_idle;
  assign divisor_out     = {div_high_q, div_low_q};

  // ----------------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------------
  // Steps of a wake-up from sleep
  sequence asleep_with_wake_s;
    sleeping_q && wake_event;
  endsequence

  sequence woken_s;
    !sleeping_q ##0 clk_en_q;
  endsequence

  AST_SLEEP_NEEDS_ENABLE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(sleeping_q) |-> $past(enh_functions_in) && $past(sleep_enable_in))
    else $error("sleep entered without both enables");

  AST_SLEEP_NEEDS_IDLE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(sleeping_q) |-> $past(rx_idle) && $past(tx_fifo_empty_in)
                          && $past(tx_shift_empty_in))
    else $error("sleep entered with line or transmitter busy");

  AST_SLEEP_IRQ: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    blocking_irq |=> !sleeping_q)
    else $error("asleep with a blocking interrupt pending");

  AST_SLEEP_RXFIFO: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !rx_fifo_empty_in |=> !sleeping_q)
    else $error("asleep with data in receive FIFO");

  AST_CLK_STOP: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    sleeping_q |-> !clk_en_q ##1 !baud_tick)
    else $error("clocks running while asleep");

  AST_WAKE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    asleep_with_wake_s |=> woken_s)
    else $error("wake event did not restart clocks");

  AST_BREAK: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    break_ctrl_in [*2] |-> !tx_q)
    else $error("transmit line not low during break");

  AST_PRESCALE_RESET: assert property (@(posedge clock_in)
    !rst_n_in |=> !prescale_q)
    else $error("prescaler not divide-by-1 after reset");

  AST_DIV_LOAD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    div_high_wr_in && !div_low_wr_in |=> divisor_out[15:8] == $past(div_data_in)
                                         && $stable(divisor_out[7:0]))
    else $error("high divisor byte not loaded");

  AST_DIV_LOW_LOAD: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    div_low_wr_in |=> divisor_out[7:0] == $past(div_data_in))
    else $error("low divisor byte not loaded");

  AST_TX_FOLLOW: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !break_ctrl_in |=> tx_q == $past(tx_data_in))
    else $error("transmit line not following data outside break");

  AST_SLEEP_NO_WAKE: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    $rose(sleeping_q) |-> !$past(wake_event))
    else $error("sleep entered in the cycle of a wake event");

  AST_RESET_AWAKE: assert property (@(posedge clock_in)
    !rst_n_in |=> !sleeping_q && clk_en_q && tx_q)
    else $error("reset did not leave the channel awake");

endmodule // uart_sleep_ctrl

// >>> divisor_host.sv
// Host model that programs the divisor bytes with sleep held off
`timescale 1ns/1ps

module divisor_host (
  input  wire logic        clock_in,
  input  wire logic        rst_n_in,
  input  wire logic        start_in,
  input  wire logic [15:0] value_in,
  output logic             low_wr_out,
  output logic             high_wr_out,
  output logic [7:0]       data_out,
  output logic             sleep_hold_out,
  output logic             busy_out
);
  logic [2:0]  step_q;
  logic [15:0] value_q;
  logic [7:0]  last_q;

  // Step sequencer: hold sleep off, settle, low byte, high byte
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      step_q <= 3'h0;
    end else if (step_q == 3'h0) begin
      if (start_in) begin
        step_q  <= 3'h1;
        value_q <= value_in;
      end
    end else begin
      step_q <= (step_q == 3'h5) ? 3'h0 : step_q + 3'h1;
    end
    if (low_wr_out || high_wr_out) begin
      last_q <= data_out;
    end
  end

  // Sleep held off for the whole update, never written while asleep
  assign sleep_hold_out = (step_q != 3'h0);
  assign busy_out       = (step_q != 3'h0);
  // Low byte carries bits 7:0, high byte bits 15:8
  assign low_wr_out     = (step_q == 3'h4);
  assign high_wr_out    = (step_q == 3'h5);
  // Idle bus shows the inverse of the last byte, never a stale copy
  assign data_out = low_wr_out ? value_q[7:0] :
                    high_wr_out ? value_q[15:8] : ~last_q;
endmodule // divisor_host

// >>> test_uart_sleep_ctrl.sv
// Self-checking bench for the UART sleep controller and baud generator
`timescale 1ns/1ps

module test_uart_sleep_ctrl;
  logic clock_in, rst_n_in, rx_pin, tx_data, enh, sen_tb, brk, presc;
  logic thr_wr, txf, txs, rxf, start, lo_wr, hi_wr, hold, busy;
  logic tx, slp, clk_en, tick, idle, seen;
  logic [1:0]  wl;
  logic [7:0]  dd;
  logic [15:0] div_val, div_seen;
  uart_sleep_pkg::modem_pins_t  modem;
  uart_sleep_pkg::irq_pending_t irq;
  int fails, check_count, cyc, n;
  typedef struct packed {logic e, s, tf, ts, rf; logic [6:0] q; logic x;} sleep_row_t;
  sleep_row_t rows [12];
  logic [15:0] t_div [5];
  logic        t_pre [5];
  int          t_per [5];

  // ---------------------------------------------------------------------
  // Design and host model
  // ---------------------------------------------------------------------
  uart_sleep_ctrl u_dut (.clock_in(clock_in), .rst_n_in(rst_n_in), .rx_pin_in(rx_pin),
    .modem_pins_in(modem), .tx_data_in(tx_data), .tx_out(tx), .enh_functions_in(enh),
    .sleep_enable_in(sen_tb & ~hold), .break_ctrl_in(brk), .word_len_in(wl),
    .prescale_sel_in(presc), .div_low_wr_in(lo_wr), .div_high_wr_in(hi_wr),
    .div_data_in(dd), .thr_write_in(thr_wr), .tx_fifo_empty_in(txf),
    .tx_shift_empty_in(txs), .rx_fifo_empty_in(rxf), .irq_pending_in(irq),
    .sleeping_out(slp), .uart_clk_en_out(clk_en), .baud_tick_out(tick),
    .rx_idle_out(idle), .divisor_out(div_seen));
  divisor_host u_host (.clock_in(clock_in), .rst_n_in(rst_n_in), .start_in(start),
    .value_in(div_val), .low_wr_out(lo_wr), .high_wr_out(hi_wr), .data_out(dd),
    .sleep_hold_out(hold), .busy_out(busy));

  // ---------------------------------------------------------------------
  // Clock, timeout and helpers
  // ---------------------------------------------------------------------
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  // Cycle ceiling well above the expected run length
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask

  task automatic chk_count(input int got, input int exp, input string msg);
    check_count++;
    if (got != exp) begin
      fails++;
      $display("CHECK FAILED %0t %s got %0d want %0d", $time, msg, got, exp);
    end
  endtask

  task automatic cyc_n(input int k);
    repeat (k) @(negedge clock_in);
  endtask

  task automatic set_div(input logic [15:0] v);
    div_val = v;
    start   = 1'b1;
    cyc_n(1);
    start   = 1'b0;
    for (int i = 0; i < 10 && busy; i++) cyc_n(1);
    cyc_n(1);
  endtask

  task automatic count_ticks(input int k, output int c);
    c = 0;
    repeat (k) begin
      @(negedge clock_in);
      if (tick === 1'b1) c++;
    end
  endtask

  task automatic wait_wake();
    seen = 1'b0;
    repeat (8) begin
      @(negedge clock_in);
      if (slp === 1'b0 && clk_en === 1'b1) seen = 1'b1;
      // Write pulse dropped after its first edge
      thr_wr = 1'b0;
    end
  endtask

  // ---------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------
  initial begin
    {rst_n_in, enh, sen_tb, brk, presc, thr_wr, start, cyc, fails, check_count} = '0;
    {rx_pin, tx_data, txf, txs, rxf} = 5'h1F;
    wl = 2'h0;
    div_val = 16'h0000;
    modem = 4'hF;
    irq = 7'h00;
    rows = '{'{1,1,1,1,1,7'h00,1}, '{0,1,1,1,1,7'h00,0}, '{1,0,1,1,1,7'h00,0},
             '{1,1,0,1,1,7'h00,0}, '{1,1,1,0,1,7'h00,0}, '{1,1,1,1,0,7'h00,0},
             '{1,1,1,1,1,7'h18,1}, '{1,1,1,1,1,7'h40,0}, '{1,1,1,1,1,7'h20,0},
             '{1,1,1,1,1,7'h04,0}, '{1,1,1,1,1,7'h01,0}, '{1,1,1,1,1,7'h02,0}};
    t_div = '{16'h0001, 16'h0002, 16'h0001, 16'h0003, 16'h0000};
    t_pre = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
    t_per = '{1, 2, 4, 12, 0};
    cyc_n(20);
    chk_bit(tx, 1'b1, "tx level in reset");
    chk_bit(slp | tick | idle | ~clk_en, 1'b0, "status in reset");
    rst_n_in = 1'b1;
    // Break forces the line low only while set
    brk = 1'b1;
    cyc_n(2);
    chk_bit(tx, 1'b0, "break low");
    brk = 1'b0;
    cyc_n(2);
    chk_bit(tx, 1'b1, "break released");
    // Tick rate per divisor and prescale row
    foreach (t_div[i]) begin
      presc = t_pre[i];
      set_div(t_div[i]);
      chk_word(div_seen, t_div[i], "divisor bytes");
      cyc_n(16);
      count_ticks(96, n);
      chk_count(n, (t_per[i] == 0) ? 0 : 96 / t_per[i], "tick count");
    end
    // Divisor survives reset; idle after the programmed bit count
    presc = 1'b0;
    set_div(16'h0001);
    rst_n_in = 1'b0;
    cyc_n(2);
    rst_n_in = 1'b1;
    chk_word(div_seen, 16'h0001, "divisor kept");
    n = 0;
    while (idle !== 1'b1 && n < 800) begin
      cyc_n(1);
      n++;
    end
    chk_bit(n >= 490 && n <= 540, 1'b1, "idle time 32 bits");
    // Longer word: idle drops, then returns after twelve more bit times
    wl = 2'h3;
    cyc_n(2);
    chk_bit(idle, 1'b0, "idle drops for 8-bit word");
    n = 0;
    while (idle !== 1'b1 && n < 400) begin
      cyc_n(1);
      n++;
    end
    chk_bit(n >= 176 && n <= 204, 1'b1, "idle time 44 bits");
    // Sleep condition table
    foreach (rows[i]) begin
      {enh, sen_tb, txf, txs, rxf, irq} = rows[i][12:1];
      cyc_n(4);
      chk_bit(slp, rows[i].x, "sleep decision");
      chk_bit(clk_en, ~rows[i].x, "clock enable");
    end
    // Asleep: no ticks, then each wake source
    {enh, sen_tb, txf, txs, rxf, irq} = {5'h1F, 7'h00};
    cyc_n(4);
    count_ticks(32, n);
    chk_count(n, 0, "ticks while asleep");
    thr_wr = 1'b1;
    wait_wake();
    chk_bit(seen, 1'b1, "wake on write");
    cyc_n(6);
    chk_bit(slp, 1'b1, "asleep again");
    modem = 4'hE;
    wait_wake();
    chk_bit(seen, 1'b1, "wake on modem");
    cyc_n(6);
    rx_pin = 1'b0;
    wait_wake();
    chk_bit(seen, 1'b1, "wake on rx");
    cyc_n(16);
    chk_bit(slp, 1'b0, "awake while line low");
    rx_pin = 1'b1;
    chk_bit(idle, 1'b0, "idle cleared by low");
    summarize();
  end
endmodule // test_uart_sleep_ctrl
